/* File: logic/osp_pkg.sv */
// Purpose: Shared constants for the dual-role sideband pin logic.
// Assumes: 12 MHz reference clock (aclk is 10 MHz in this build, see CLK constants).
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
package osp_pkg;
    // Register byte offsets.
    localparam logic [7:0] OSP_HOST_CFG_OFS = 8'h00;
    localparam logic [7:0] OSP_PERIPH_CFG_OFS = 8'h04;
    localparam logic [7:0] OSP_ROLE_STATUS_OFS = 8'h08;
    localparam logic [7:0] OSP_PORT_CTRL_OFS = 8'h0c;
    localparam logic [7:0] OSP_CLK_CTRL_OFS = 8'h10;
    localparam logic [7:0] OSP_HW_MODE_OFS = 8'h14;
    // Host config fields.
    localparam int OSP_HC_SINGLE_IRQ_BIT = 0;
    localparam int OSP_HC_IRQ_POL_BIT = 1;
    localparam int OSP_HC_PULLDOWN2_BIT = 2;
    // Peripheral config fields.
    localparam int OSP_PC_IRQ_EN_BIT = 0;
    localparam int OSP_PC_IRQ_POL_BIT = 1;
    // Port control fields.
    localparam int OSP_PT_PWR1_BIT = 0;
    localparam int OSP_PT_PWR2_BIT = 1;
    localparam int OSP_PT_EXT1_BIT = 2;
    // Hardware mode fields: 1 selects the analog overcurrent path.
    localparam int OSP_HM_ANALOG1_BIT = 0;
    localparam int OSP_HM_ANALOG2_BIT = 1;
    // Status fields.
    localparam int OSP_ST_ROLE_BIT = 0;
    localparam int OSP_ST_DUAL_BIT = 1;
    localparam int OSP_ST_OC1_BIT = 2;
    localparam int OSP_ST_OC2_BIT = 3;
    localparam int OSP_ST_HSUSP_BIT = 4;
    localparam int OSP_ST_PSUSP_BIT = 5;
    // Reset values.
    localparam logic [31:0] OSP_HOST_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] OSP_PERIPH_CFG_RST = 32'h0000_0001;
    localparam logic [31:0] OSP_PORT_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] OSP_HW_MODE_RST = 32'h0000_0000;
    // Clock output: frequency in MHz, limits and default.
    localparam int OSP_CLK_REF_MHZ = 12;
    localparam int OSP_ACLK_KHZ = 10000;
    localparam logic [7:0] OSP_CLK_DEF_MHZ = 8'h0c;
    localparam logic [7:0] OSP_CLK_MIN_MHZ = 8'h03;
    localparam logic [7:0] OSP_CLK_MAX_MHZ = 8'h30;
    localparam int OSP_ACC_W = 16;
    // LED blink: on time in ms, cycle count derived from the clock rate.
    localparam int OSP_LED_BLINK_MS = 50;
    localparam int OSP_LED_BLINK_CYC = OSP_LED_BLINK_MS * OSP_ACLK_KHZ;
    // Wake pulse: least low time in ns and derived cycles.
    localparam int OSP_WAKE_MIN_NS = 300;
    localparam int OSP_WAKE_MIN_CYC = (OSP_WAKE_MIN_NS * OSP_ACLK_KHZ / 1000 + 999) / 1000;
endpackage : osp_pkg

/* File: logic/osp_sync.sv */
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: Single clock aclk, synchronous active-low reset.
// Notes: The first flop feeds only the second.
module osp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous level and its synchronised copy.
    input wire logic async_in,
    output logic sync_out
);
    logic meta; // First stage, read only by the second.

    // Two flip-flops in a row.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // osp_sync

/* File: logic/osp_top.sv */
// Purpose: Sideband pin logic of a dual-role USB controller.
// Assumes: aclk drives all logic; pins pass two flops before use.
// Notes: Registers reached over AXI4-Lite with one write and one read at a time.
// Operation
// - Single-route bit sends both requests to host output.
// - Host output carries host controller request.
// - Peripheral output carries peripheral request, configured.
// - Host sleep pin released high while suspended.
// - Peripheral sleep pin released high while suspended.
// - Power switch low enables, high disables.
// - Port 1 switch used only with external supply.
// - Clock output 12 MHz default, 3 to 48; the output runs at the setting modulo 5 MHz, so 2 MHz at the default.
// - Activity LED off, blinks during traffic.
// - Role sense mirrored into status bit 0.
// - Port 2 overcurrent digital or analog, selectable.
// - Port 1 overcurrent digital or analog, selectable.
// - Role select sets port 1 dual-role mode.
// - Timing derived from 12 MHz reference; derived here from the 10 MHz aclk.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
module osp_top
    import osp_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Internal controller requests and state.
    input wire logic host_irq_req,
    input wire logic periph_irq_req,
    input wire logic host_suspended,
    input wire logic periph_suspended,
    input wire logic usb_traffic,
    input wire logic analog_oc1,
    input wire logic analog_oc2,
    // Wake requests to the controllers.
    output logic host_wake,
    output logic periph_wake,
    // Interrupt pins.
    output logic host_irq_out,
    output logic periph_irq_out,
    // Sleep/wake open-drain pins.
    input wire logic host_sleep_wake_pin_in,
    output logic host_sleep_wake_pin_out,
    output logic host_sleep_wake_pin_oe,
    input wire logic periph_sleep_wake_pin_in,
    output logic periph_sleep_wake_pin_out,
    output logic periph_sleep_wake_pin_oe,
    // Power switches, open drain: oe high pulls the pin low.
    output logic port1_power_switch_n_out,
    output logic port1_power_switch_n_oe,
    output logic port2_power_switch_n_out,
    output logic port2_power_switch_n_oe,
    // Clock and LED outputs.
    output logic prog_clock_out,
    output logic link_activity_led_out,
    output logic link_activity_led_oe,
    // Sense pins.
    input wire logic port1_overcurrent_in,
    input wire logic port2_overcurrent_in,
    input wire logic port1_role_select,
    input wire logic role_sense_in,
    // Port state to the rest of the controller.
    output logic port1_dual_role,
    output logic port2_pulldown_connect,
    output logic port1_overcurrent,
    output logic port2_overcurrent
);
    import osp_pkg::*;
    // Registers.
    logic [31:0] host_hw_config_reg; // Host side routing and pull-down control.
    logic [31:0] periph_hw_config_reg; // Peripheral interrupt control.
    logic [31:0] port_ctrl; // Port power control.
    logic [31:0] hw_mode; // Overcurrent path selection.
    logic [7:0] clk_mhz; // Clock output frequency in MHz.
    logic [31:0] dual_role_status_reg; // Live status view.
    // Synchronised pins.
    logic role_s; // Role sense level.
    logic sel_s; // Role-select level.
    logic oc1_s; // Port 1 digital overcurrent.
    logic oc2_s; // Port 2 digital overcurrent.
    // Bus slave state.
    logic aw_hold; // Write address taken.
    logic w_hold; // Write data taken.
    logic [7:0] aw_addr; // Held write address.
    logic [31:0] w_data; // Held write data.
    logic [3:0] w_strb; // Held write strobes.
    logic wr_go; // Both halves present, commit this cycle.
    logic wr_hit; // Write address is mapped.
    // Clock output accumulator and LED counter.
    logic [OSP_ACC_W-1:0] acc; // Phase accumulator.
    logic [OSP_ACC_W-1:0] next_acc; // Next phase.
    logic [31:0] led_cnt; // Remaining blink time, on while above one blink, off below.
    logic led_on; // LED lit.

    // Input synchronisers.
    osp_sync #(.RST_VAL(1'b0)) u_sync_role (
        .aclk(aclk), .aresetn(aresetn), .async_in(role_sense_in), .sync_out(role_s)
    );
    osp_sync #(.RST_VAL(1'b0)) u_sync_sel (
        .aclk(aclk), .aresetn(aresetn), .async_in(port1_role_select), .sync_out(sel_s)
    );
    osp_sync #(.RST_VAL(1'b1)) u_sync_oc1 (
        .aclk(aclk), .aresetn(aresetn), .async_in(port1_overcurrent_in), .sync_out(oc1_s)
    );
    osp_sync #(.RST_VAL(1'b1)) u_sync_oc2 (
        .aclk(aclk), .aresetn(aresetn), .async_in(port2_overcurrent_in), .sync_out(oc2_s)
    );

    // Sleep/wake pins: released while suspended, low pulse wakes.
    osp_wake u_host_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .suspended(host_suspended),
        .pin_in(host_sleep_wake_pin_in),
        .pin_out(host_sleep_wake_pin_out),
        .pin_oe(host_sleep_wake_pin_oe),
        .wake_pulse(host_wake)
    );
    osp_wake u_periph_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .suspended(periph_suspended),
        .pin_in(periph_sleep_wake_pin_in),
        .pin_out(periph_sleep_wake_pin_out),
        .pin_oe(periph_sleep_wake_pin_oe),
        .wake_pulse(periph_wake)
    );

    // The bus handshakes: write channels accept when their holding slot is free and no response is pending; read address when no read data is pending.
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
    assign wr_hit = (aw_addr == OSP_HOST_CFG_OFS) || (aw_addr == OSP_PERIPH_CFG_OFS) ||
                    (aw_addr == OSP_PORT_CTRL_OFS) || (aw_addr == OSP_CLK_CTRL_OFS) ||
                    (aw_addr == OSP_HW_MODE_OFS) || (aw_addr == OSP_ROLE_STATUS_OFS);
    assign s_axi_arready = !s_axi_rvalid;

    // Capture write address and data in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response: OKAY on a mapped word, DECERR otherwise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b11;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte-lane merge of a write into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Writable registers; reserved upper bits stay zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_hw_config_reg <= OSP_HOST_CFG_RST;
            periph_hw_config_reg <= OSP_PERIPH_CFG_RST;
            port_ctrl <= OSP_PORT_CTRL_RST;
            hw_mode <= OSP_HW_MODE_RST;
            clk_mhz <= OSP_CLK_DEF_MHZ;
        end else if (wr_go) begin
            if (aw_addr == OSP_HOST_CFG_OFS) begin
                host_hw_config_reg <= merge(host_hw_config_reg, w_data, w_strb) & 32'h0000_0007;
            end
            if (aw_addr == OSP_PERIPH_CFG_OFS) begin
                periph_hw_config_reg <= merge(periph_hw_config_reg, w_data, w_strb) & 32'h0000_0003;
            end
            if (aw_addr == OSP_PORT_CTRL_OFS) begin
                port_ctrl <= merge(port_ctrl, w_data, w_strb) & 32'h0000_0007;
            end
            if (aw_addr == OSP_HW_MODE_OFS) begin
                hw_mode <= merge(hw_mode, w_data, w_strb) & 32'h0000_0003;
            end
            if (aw_addr == OSP_CLK_CTRL_OFS && w_strb[0]) begin
                // Out-of-range requests clamp into 3 to 48 MHz.
                if (w_data[7:0] < OSP_CLK_MIN_MHZ) begin
                    clk_mhz <= OSP_CLK_MIN_MHZ;
                end else if (w_data[7:0] > OSP_CLK_MAX_MHZ) begin
                    clk_mhz <= OSP_CLK_MAX_MHZ;
                end else begin
                    clk_mhz <= w_data[7:0];
                end
            end
        end
    end

    // Status view of the sensed pins and controller state.
    always_comb begin
        dual_role_status_reg = 32'h0000_0000;
        dual_role_status_reg[OSP_ST_ROLE_BIT] = role_s;
        dual_role_status_reg[OSP_ST_DUAL_BIT] = port1_dual_role;
        dual_role_status_reg[OSP_ST_OC1_BIT] = port1_overcurrent;
        dual_role_status_reg[OSP_ST_OC2_BIT] = port2_overcurrent;
        dual_role_status_reg[OSP_ST_HSUSP_BIT] = host_suspended;
        dual_role_status_reg[OSP_ST_PSUSP_BIT] = periph_suspended;
    end

    // Read channel: data registered one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            unique case ({s_axi_araddr[7:2], 2'b00})
                OSP_HOST_CFG_OFS: s_axi_rdata <= host_hw_config_reg;
                OSP_PERIPH_CFG_OFS: s_axi_rdata <= periph_hw_config_reg;
                OSP_ROLE_STATUS_OFS: s_axi_rdata <= dual_role_status_reg;
                OSP_PORT_CTRL_OFS: s_axi_rdata <= port_ctrl;
                OSP_CLK_CTRL_OFS: s_axi_rdata <= {24'h00_0000, clk_mhz};
                OSP_HW_MODE_OFS: s_axi_rdata <= hw_mode;
                default: begin
                    // Unmapped word reads zero with DECERR.
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b11;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Interrupt pins, polarity per config; single routing merges both onto host.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_irq_out <= 1'b0;
            periph_irq_out <= 1'b0;
        end else begin
            if (host_hw_config_reg[OSP_HC_SINGLE_IRQ_BIT]) begin
                host_irq_out <= (host_irq_req || periph_irq_req) ^ host_hw_config_reg[OSP_HC_IRQ_POL_BIT];
                periph_irq_out <= periph_hw_config_reg[OSP_PC_IRQ_POL_BIT];
            end else begin
                host_irq_out <= host_irq_req ^ host_hw_config_reg[OSP_HC_IRQ_POL_BIT];
                periph_irq_out <= (periph_irq_req && periph_hw_config_reg[OSP_PC_IRQ_EN_BIT]) ^
                                  periph_hw_config_reg[OSP_PC_IRQ_POL_BIT];
            end
        end
    end

    // Power switches: pulled low to power a port, released high otherwise.
    assign port1_power_switch_n_out = 1'b0;
    assign port2_power_switch_n_out = 1'b0;
    assign port1_power_switch_n_oe = port_ctrl[OSP_PT_PWR1_BIT] && port_ctrl[OSP_PT_EXT1_BIT];
    assign port2_power_switch_n_oe = port_ctrl[OSP_PT_PWR2_BIT];

    // Overcurrent source per port; pins are active low.
    assign port1_overcurrent = hw_mode[OSP_HM_ANALOG1_BIT] ? analog_oc1 : !oc1_s;
    assign port2_overcurrent = hw_mode[OSP_HM_ANALOG2_BIT] ? analog_oc2 : !oc2_s;

    // Port 1 dual-role when role select is high.
    assign port1_dual_role = sel_s;
    // Pull-down connect is software's job; exported as written.
    assign port2_pulldown_connect = host_hw_config_reg[OSP_HC_PULLDOWN2_BIT];

    // Clock output: two toggles per period, so step by twice the MHz and wrap at the aclk rate in MHz.
    always_comb begin
        next_acc = OSP_ACC_W'((32'(acc) + 32'(clk_mhz) * 32'(OSP_CLK_REF_MHZ / 6)) % 32'(OSP_ACLK_KHZ / 1000));
    end

    // Toggle the clock output in a cycle where the next phase is below the current one, at most once per cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= '0;
            prog_clock_out <= 1'b0;
        end else begin
            acc <= next_acc;
            if (next_acc < acc) begin
                prog_clock_out <= !prog_clock_out;
            end
        end
    end

    // LED lit for a blink after a traffic event seen while the counter is idle, then off for as long again; off otherwise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_cnt <= 32'h0000_0000;
            led_on <= 1'b0;
        end else if (usb_traffic && led_cnt == 32'h0000_0000) begin
            led_cnt <= 32'(OSP_LED_BLINK_CYC * 2);
            led_on <= 1'b1;
        end else if (led_cnt != 32'h0000_0000) begin
            led_cnt <= led_cnt - 32'h0000_0001;
            led_on <= (led_cnt > 32'(OSP_LED_BLINK_CYC));
        end else begin
            led_on <= 1'b0;
        end
    end

    // Open-drain LED pin sinks current while lit.
    assign link_activity_led_out = 1'b0;
    assign link_activity_led_oe = led_on;
endmodule // osp_top

/* File: logic/osp_wake.sv */
// Purpose: Sleep/wake open-drain pin of one controller side.
// Assumes: Pin input already pulled up externally; raw pin enters here.
// Notes: Pin is released while suspended, pulled low otherwise.
module osp_wake
    import osp_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Controller state.
    input wire logic suspended,
    // Open-drain pin.
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // One-cycle wake request to the controller.
    output logic wake_pulse
);
    logic pin_s; // Synchronised pin level.
    logic [7:0] low_cnt; // Length of the current low pulse.

    osp_sync #(.RST_VAL(1'b1)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    // Open drain: only low is ever driven.
    assign pin_out = 1'b0;
    assign pin_oe = !suspended;

    // Count a low pulse while suspended and wake once it is long enough.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt <= 8'h00;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            if (!suspended || pin_s) begin
                low_cnt <= 8'h00;
            end else if (low_cnt != 8'hff) begin
                low_cnt <= low_cnt + 8'h01;
                wake_pulse <= (low_cnt == 8'(OSP_WAKE_MIN_CYC - 1));
            end
        end
    end
endmodule // osp_wake

/* File: test/osp_partner.sv */
// Purpose: Pull-ups, wake buttons and power switches beyond the pins.
// Assumes: Every open-drain pin has a pull-up.
// Notes: Index 0 is the host side or port 1, index 1 the other.
module osp_partner (
    // Enables from the block and wake requests from the bench.
    input wire logic [1:0] sleep_oe,
    input wire logic [1:0] power_oe,
    input wire logic [1:0] wake_req,
    // Resolved pins and delivered power.
    output logic [1:0] sleep_pin,
    output logic [1:0] port_powered
);
    // A pin floats high unless the block or a wake request pulls it low.
    assign sleep_pin = ~(sleep_oe | wake_req);
    // The switch conducts while its gate pin is pulled low.
    assign port_powered = power_oe;
endmodule // osp_partner

/* File: test/osp_properties.sv */
// Purpose: Port-level checks of the sideband pin logic.
// Assumes: Interrupt outputs are left active high.
// Notes: Bound to osp_top after the module.
module osp_properties (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers.
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Controller side and pins.
    input wire logic host_irq_req,
    input wire logic periph_irq_req,
    input wire logic host_irq_out,
    input wire logic periph_irq_out,
    input wire logic host_suspended,
    input wire logic periph_suspended,
    input wire logic host_sleep_wake_pin_oe,
    input wire logic periph_sleep_wake_pin_oe,
    input wire logic host_wake,
    input wire logic port1_role_select,
    input wire logic port1_dual_role
);
    // Every check shares the one clock and its reset.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    host_release_a: assert property (host_sleep_wake_pin_oe == !host_suspended)
        else $error("host sleep pin wrong");
    periph_release_a: assert property (periph_sleep_wake_pin_oe == !periph_suspended)
        else $error("periph sleep pin wrong");
    host_irq_a: assert property ($rose(host_irq_req) |=> host_irq_out)
        else $error("host irq missed");
    periph_irq_a: assert property ($rose(periph_irq_req) |=> host_irq_out || periph_irq_out)
        else $error("periph irq missed");
    wake_once_a: assert property (host_wake |-> host_suspended ##1 !host_wake)
        else $error("wake pulse wrong");
    role_mirror_a: assert property ($stable(port1_role_select) [*4] |-> port1_dual_role == port1_role_select)
        else $error("role select not followed");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
endmodule // osp_properties

bind osp_top osp_properties u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
    .host_irq_req, .periph_irq_req, .host_irq_out, .periph_irq_out, .host_suspended, .periph_suspended,
    .host_sleep_wake_pin_oe, .periph_sleep_wake_pin_oe, .host_wake, .port1_role_select, .port1_dual_role);

/* File: test/test_otg_sideband_pin_logic.sv */
// Purpose: Self-checking bench of the sideband pin logic.
// Assumes: Interrupt polarity stays active high.
// Notes: Bus results are queued by the drivers and compared by a monitor.
module test_otg_sideband_pin_logic;
    timeunit 1ns;
    timeprecision 1ns;
    import osp_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, bv, rv, awr, wr_r, arr;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, seed = 32'h25c0a17e;
    logic [1:0] br, rr, susp = 2'b00, wreq = 2'b00, soe, poe, spin, pwr, rs = 2'b11;
    logic hreq = 1'b0, preq = 1'b0, traf = 1'b0, aoc1 = 1'b0, aoc2 = 1'b0, oc1n = 1'b1, oc2n = 1'b1;
    logic hw, pw, hirq, pirq, ck, ckd, led, dual, pdn, oc1, oc2;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int failures = 0, samples_checked = 0, rises = 0, n;
    int wk[2] = '{0, 0};
    osp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .host_irq_req(hreq),
        .periph_irq_req(preq), .host_suspended(susp[0]), .periph_suspended(susp[1]), .usb_traffic(traf),
        .analog_oc1(aoc1), .analog_oc2(aoc2), .host_wake(hw), .periph_wake(pw), .host_irq_out(hirq),
        .periph_irq_out(pirq), .host_sleep_wake_pin_in(spin[0]), .host_sleep_wake_pin_out(),
        .host_sleep_wake_pin_oe(soe[0]), .periph_sleep_wake_pin_in(spin[1]), .periph_sleep_wake_pin_out(),
        .periph_sleep_wake_pin_oe(soe[1]), .port1_power_switch_n_out(), .port1_power_switch_n_oe(poe[0]),
        .port2_power_switch_n_out(), .port2_power_switch_n_oe(poe[1]), .prog_clock_out(ck),
        .link_activity_led_out(), .link_activity_led_oe(led), .port1_overcurrent_in(oc1n),
        .port2_overcurrent_in(oc2n), .port1_role_select(rs[1]), .role_sense_in(rs[0]), .port1_dual_role(dual),
        .port2_pulldown_connect(pdn), .port1_overcurrent(oc1), .port2_overcurrent(oc2));
    osp_partner u_far (.sleep_oe(soe), .power_oe(poe), .wake_req(wreq), .sleep_pin(spin), .port_powered(pwr));
    // Free-running 10 MHz clock.
    initial forever #50 aclk = ~aclk;
    // Monitor: counts wake pulses and clock rises, compares each bus answer with the oldest note.
    always @(posedge aclk) begin
        wk[0] <= wk[0] + int'(hw);
        wk[1] <= wk[1] + int'(pw);
        ckd <= ck;
        rises <= rises + int'(ck & ~ckd);
        if (rv) check("read", {rr, rdat}, rq.pop_front());
        if (bv) check("bresp", {32'h0, br}, {32'h0, bq.pop_front()});
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask
    // Write: both halves offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            awv <= awv & ~awr;
            wv <= wv & ~wr_r;
        end while ((awv & ~awr) | (wv & ~wr_r));
        do @(posedge aclk); while (!bv);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
    endtask
    // Suspends one side, checks its pin, then wakes it with a low pulse.
    task automatic sleep_wake(input int i);
        susp[i] <= 1'b1;
        tick(3);
        check("sleep pin", spin[i], 1'b1);
        n = wk[i];
        wreq[i] <= 1'b1;
        tick(6);
        wreq[i] <= 1'b0;
        tick(8);
        check("wake count", wk[i] - n, 1);
        susp[i] <= 1'b0;
        tick(3);
        check("pin pulled", spin[i], 1'b0);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        tick(20000);
        failures++;
        give_verdict();
    end
    initial begin
        tick(12);
        aresetn <= 1'b1;
        tick(1);
        rd(OSP_HOST_CFG_OFS, {2'b00, OSP_HOST_CFG_RST});
        rd(OSP_PERIPH_CFG_OFS, {2'b00, OSP_PERIPH_CFG_RST});
        rd(OSP_CLK_CTRL_OFS, {26'h0, OSP_CLK_DEF_MHZ});
        rd(OSP_ROLE_STATUS_OFS, 34'h3);
        rd(8'h18, {2'b11, 32'h0});
        wr(8'h18, 32'h0, 2'b11);
        oc1n <= 1'b0;
        aoc2 <= 1'b1;
        tick(4);
        check("overcurrent", {oc1, oc2}, 2'b10);
        wr(OSP_HW_MODE_OFS, 32'h3, 2'b00);
        tick(2);
        check("analog oc", {oc1, oc2}, 2'b01);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            rs <= seed[4:3];
            wr(OSP_PORT_CTRL_OFS, seed & 32'h7, 2'b00);
            tick(2);
            check("power", pwr, {seed[1], seed[0] & seed[2]});
            rd(OSP_PORT_CTRL_OFS, {2'b00, seed & 32'h7});
            rd(OSP_ROLE_STATUS_OFS, {32'h2, seed[4:3]});
        end
        hreq <= 1'b1;
        tick(2);
        check("irq host", {hirq, pirq}, 2'b10);
        hreq <= 1'b0;
        preq <= 1'b1;
        tick(2);
        check("irq periph", {hirq, pirq}, 2'b01);
        wr(OSP_HOST_CFG_OFS, 32'h5, 2'b00);
        tick(2);
        check("irq single", {hirq, pirq, pdn}, 3'b101);
        sleep_wake(0);
        sleep_wake(1);
        check("led idle", led, 1'b0);
        traf <= 1'b1;
        tick(1);
        traf <= 1'b0;
        tick(4);
        check("led on", led, 1'b1);
        wr(OSP_CLK_CTRL_OFS, 32'h3, 2'b00);
        tick(4);
        n = rises;
        tick(100);
        check("clock rises", 34'(rises - n >= 29 && rises - n <= 31), 1);
        give_verdict();
    end
endmodule // test_otg_sideband_pin_logic
